// ==== common/vardx_defines.svh ====
`ifndef VARDX_DEFINES_SVH
`define VARDX_DEFINES_SVH

// frame layout and framing counts
`define VARDX_FRAME_LAST 4'h8
`define VARDX_MODULE_ADDR 8'h01
`define VARDX_HOST_ADDR 8'h02

// opcodes
`define VARDX_OPC_CALC 8'h2D
`define VARDX_OPC_RESTART 8'h30
`define VARDX_OPC_DECBR 8'h31

// reply status codes
`define VARDX_STAT_OK 8'h64
`define VARDX_STAT_BAD_CSUM 8'h01
`define VARDX_STAT_BAD_CMD 8'h02
`define VARDX_STAT_BAD_TYPE 8'h03
`define VARDX_STAT_BAD_VAL 8'h04

// reset values
`define VARDX_WORD_RST 32'h0000_0000

`endif

// ==== common/vardx_pkg.sv ====
`default_nettype none
package vardx_pkg;

  typedef enum logic [3:0] {
    VARDX_ADD = 4'b0000,
    VARDX_SUB = 4'b0001,
    VARDX_PRODUCT_OP = 4'b0010,
    VARDX_DIV = 4'b0011,
    VARDX_REMAINDER_OP = 4'b0100,
    VARDX_AND = 4'b0101,
    VARDX_OR = 4'b0110,
    VARDX_XOR = 4'b0111,
    VARDX_NOT = 4'b1000,
    VARDX_LOAD = 4'b1001,
    VARDX_COMP = 4'b1011
  } vardx_op_e;

  typedef enum logic [1:0] {
    VARDX_S_RECV = 2'b00,
    VARDX_S_EXEC = 2'b01,
    VARDX_S_REPLY = 2'b10
  } vardx_state_e;

  typedef struct packed {
    logic [7:0] target;
    logic [7:0] opcode;
    logic [7:0] optype;
    logic [7:0] bank;
    logic [31:0] value;
    logic [7:0] csum;
  } vardx_frame_s;

  typedef struct packed {
    logic [7:0] host;
    logic [7:0] target;
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
    logic [7:0] csum;
  } vardx_reply_s;

  typedef struct packed {
    logic zero;
    logic equal;
    logic greater;
    logic less;
  } vardx_flags_s;

endpackage
`default_nettype wire

// ==== rtl/vardx_alu.sv ====
`default_nettype none
module vardx_alu (
  input wire logic [7:0] opType,
  input wire logic [31:0] varIn,
  input wire logic [31:0] operand,
  output logic [31:0] result,
  output logic writeVar,
  output logic isCompare,
  output logic typeOk,
  output logic divZero
);
  import vardx_pkg::*;

  logic signed [31:0] a;
  logic signed [31:0] b;
  assign a = varIn;
  assign b = operand;

  // all operations signed 32 bit, results wrap
  always_comb begin
    result = varIn;
    writeVar = 1'b0;
    isCompare = 1'b0;
    typeOk = (opType[7:4] == 4'h0);
    divZero = 1'b0;
    if (typeOk) begin
      unique case (vardx_op_e'(opType[3:0]))
        VARDX_ADD: begin result = a + b; writeVar = 1'b1; end
        VARDX_SUB: begin result = a - b; writeVar = 1'b1; end
        VARDX_PRODUCT_OP: begin result = a * b; writeVar = 1'b1; end
        VARDX_DIV: begin
          // divide by zero leaves the variable alone
          divZero = (b == 32'sh0000_0000);
          writeVar = !divZero;
          if (!divZero) result = a / b;
        end
        VARDX_REMAINDER_OP: begin
          divZero = (b == 32'sh0000_0000);
          writeVar = !divZero;
          if (!divZero) result = a % b;
        end
        VARDX_AND: begin result = a & b; writeVar = 1'b1; end
        VARDX_OR: begin result = a | b; writeVar = 1'b1; end
        VARDX_XOR: begin result = a ^ b; writeVar = 1'b1; end
        VARDX_NOT: begin result = ~a; writeVar = 1'b1; end
        VARDX_LOAD: begin result = b; writeVar = 1'b1; end
        VARDX_COMP: isCompare = 1'b1;
        // swap and unused codes are not offered here
        default: typeOk = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== rtl/vardx_exec.sv ====
`include "vardx_defines.svh"
`default_nettype none
module vardx_exec #(
  parameter logic [7:0] MODULE_ADDR = `VARDX_MODULE_ADDR,
  parameter logic [7:0] HOST_ADDR = `VARDX_HOST_ADDR
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic standaloneMode,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic pcLoad,
  output logic pcStep,
  output logic [31:0] pcTarget,
  output logic ctxClear,
  output vardx_pkg::vardx_flags_s condFlags
);
  import vardx_pkg::*;

  function automatic logic [7:0] byteSum(input logic [63:0] bytes);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      acc = acc + bytes[i*8 +: 8];
    end
    return acc;
  endfunction

  vardx_state_e state_r;
  logic [3:0] rxCount_r;
  logic [3:0] txCount_r;
  vardx_frame_s frame_r;
  vardx_reply_s reply_r;
  vardx_reply_s replyNxt;
  vardx_flags_s flags_r;
  logic [31:0] userVar_r [256];
  logic pcLoad_r;
  logic pcStep_r;
  logic ctxClear_r;
  logic [31:0] pcTarget_r;

  logic inExec;
  logic addrOk;
  logic csumOk;
  logic isCalc;
  logic isRestart;
  logic isDecBr;
  logic doExec;
  logic [7:0] varIdx;
  logic [7:0] status;
  logic [31:0] operand;
  logic [31:0] varCur;
  logic [31:0] decVal;
  logic [31:0] aluResult;
  logic aluWrite;
  logic aluCompare;
  logic aluTypeOk;
  logic aluDivZero;

  assign rxReady = (state_r == VARDX_S_RECV);
  assign txValid = (state_r == VARDX_S_REPLY);
  assign txData = reply_r.host;
  assign pcLoad = pcLoad_r;
  assign pcStep = pcStep_r;
  assign pcTarget = pcTarget_r;
  assign ctxClear = ctxClear_r;
  assign condFlags = flags_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the collected frame
  assign inExec = (state_r == VARDX_S_EXEC);
  // frames for another address are dropped without a reply
  assign addrOk = (frame_r.target == MODULE_ADDR);
  assign csumOk = (byteSum(frame_r[71:8]) == frame_r.csum);
  assign isCalc = (frame_r.opcode == `VARDX_OPC_CALC);
  assign isRestart = (frame_r.opcode == `VARDX_OPC_RESTART);
  assign isDecBr = (frame_r.opcode == `VARDX_OPC_DECBR);
  assign varIdx = isDecBr ? frame_r.optype : frame_r.bank;
  assign operand = frame_r.value;
  assign varCur = userVar_r[varIdx];
  assign decVal = varCur - 32'h0000_0001;

  vardx_alu u_alu (
    .opType(frame_r.optype),
    .varIn(varCur),
    .operand(operand),
    .result(aluResult),
    .writeVar(aluWrite),
    .isCompare(aluCompare),
    .typeOk(aluTypeOk),
    .divZero(aluDivZero)
  );

  always_comb begin
    status = `VARDX_STAT_OK;
    if (!csumOk) begin
      status = `VARDX_STAT_BAD_CSUM;
    end else if (isCalc) begin
      if (!aluTypeOk) status = `VARDX_STAT_BAD_TYPE;
      else if (aluDivZero) status = `VARDX_STAT_BAD_VAL;
    end else if (!(isRestart || isDecBr) || !standaloneMode) begin
      status = `VARDX_STAT_BAD_CMD;
    end
  end

  assign doExec = inExec && addrOk && (status == `VARDX_STAT_OK);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: collect nine bytes, execute one cycle, reply in direct mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= VARDX_S_RECV;
      rxCount_r <= 4'h0;
      txCount_r <= 4'h0;
    end else begin
      unique case (state_r)
        VARDX_S_RECV: begin
          if (rxValid) begin
            rxCount_r <= rxCount_r + 4'h1;
            if (rxCount_r == `VARDX_FRAME_LAST) begin
              rxCount_r <= 4'h0;
              state_r <= VARDX_S_EXEC;
            end
          end
        end
        VARDX_S_EXEC: begin
          txCount_r <= 4'h0;
          state_r <= (addrOk && !standaloneMode) ? VARDX_S_REPLY : VARDX_S_RECV;
        end
        VARDX_S_REPLY: begin
          if (txReady) begin
            txCount_r <= txCount_r + 4'h1;
            if (txCount_r == `VARDX_FRAME_LAST) state_r <= VARDX_S_RECV;
          end
        end
        default: state_r <= VARDX_S_RECV;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_r <= '0;
    end else if (rxReady && rxValid) begin
      frame_r <= {frame_r[63:0], rxData};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply assembly; value echoes the operand
  always_comb begin
    replyNxt.host = HOST_ADDR;
    replyNxt.target = MODULE_ADDR;
    replyNxt.status = status;
    replyNxt.opcode = frame_r.opcode;
    replyNxt.value = operand;
    replyNxt.csum = 8'h00;
    replyNxt.csum = byteSum(replyNxt[71:8]);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reply_r <= '0;
    end else if (inExec) begin
      reply_r <= replyNxt;
    end else if (txValid && txReady) begin
      reply_r <= {reply_r[63:0], 8'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user variables; not touched by restart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        userVar_r[i] <= `VARDX_WORD_RST;
      end
    end else if (doExec && isCalc && aluWrite) begin
      userVar_r[varIdx] <= aluResult;
    end else if (doExec && isDecBr) begin
      userVar_r[varIdx] <= decVal;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_r <= '0;
    end else if (doExec && isRestart) begin
      flags_r <= '0;
    end else if (doExec && isCalc && aluCompare) begin
      flags_r.equal <= (varCur == operand);
      flags_r.greater <= ($signed(varCur) > $signed(operand));
      flags_r.less <= ($signed(varCur) < $signed(operand));
      flags_r.zero <= (varCur == operand);
    end else if (doExec && isCalc && aluWrite) begin
      flags_r.zero <= (aluResult == `VARDX_WORD_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter control, only meaningful in standalone mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pcLoad_r <= 1'b0;
      pcStep_r <= 1'b0;
      ctxClear_r <= 1'b0;
      pcTarget_r <= `VARDX_WORD_RST;
    end else begin
      pcLoad_r <= 1'b0;
      pcStep_r <= 1'b0;
      ctxClear_r <= 1'b0;
      if (inExec && addrOk && standaloneMode) begin
        if (doExec && isRestart) begin
          ctxClear_r <= 1'b1;
          pcLoad_r <= 1'b1;
          pcTarget_r <= operand;
        end else if (doExec && isDecBr && decVal != `VARDX_WORD_RST) begin
          pcLoad_r <= 1'b1;
          pcTarget_r <= operand;
        end else begin
          // a faulty program word still advances, so the program cannot hang
          pcStep_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence calcFires(logic [3:0] t);
    doExec && isCalc && frame_r.optype == {4'h0, t};
  endsequence

  sequence replyOpens;
    txValid && txCount_r == 4'h0 && txData == HOST_ADDR;
  endsequence

  chk_add_result: assert property (
    calcFires(4'h0) |=> userVar_r[$past(varIdx)] == $past(varCur) + $past(operand))
    else $error("add result not written back");
  chk_and_result: assert property (
    calcFires(4'h5) |=> userVar_r[$past(varIdx)] == ($past(varCur) & $past(operand)))
    else $error("and result not written back");
  chk_not_invert: assert property (
    calcFires(4'h8) |=> userVar_r[$past(varIdx)] == ~$past(varCur))
    else $error("invert wrong");
  chk_load_copy: assert property (
    calcFires(4'h9) |=> userVar_r[$past(varIdx)] == $past(operand) && condFlags.zero == ($past(operand) == 0))
    else $error("load wrong");
  chk_compare_keeps: assert property (
    calcFires(4'hB) |=> userVar_r[$past(varIdx)] == $past(varCur)
      && condFlags.equal == ($past(varCur) == $past(operand)))
    else $error("compare altered variable or flags wrong");
  chk_reply_ok: assert property (
    inExec && addrOk && !standaloneMode && isCalc && csumOk && aluTypeOk && !aluDivZero
      |=> replyOpens ##0 reply_r.status == `VARDX_STAT_OK)
    else $error("direct arithmetic reply not ok");
  chk_frame_nine: assert property (
    $rose(inExec) |-> $past(rxCount_r) == `VARDX_FRAME_LAST && $past(rxValid))
    else $error("execution without nine bytes");
  // reply bytes taken, counted apart from the sequencer so the length check is not circular
  logic [3:0] replyTaken_r;
  always_ff @(posedge ref_clk) begin
    if (reset || !txValid) begin
      replyTaken_r <= 4'h0;
    end else if (txReady) begin
      replyTaken_r <= replyTaken_r + 4'h1;
    end
  end

  chk_reply_nine: assert property (
    txValid && txReady && replyTaken_r == 4'h8 |=> !txValid && rxReady)
    else $error("reply not nine bytes");
  chk_reply_length: assert property (
    $fell(txValid) |-> $past(replyTaken_r) == 4'h8)
    else $error("reply ended early");
  chk_csum_gate: assert property (
    inExec && !csumOk |-> !doExec ##1 !pcLoad && !ctxClear)
    else $error("bad checksum executed");
  chk_restart_clear: assert property (
    doExec && isRestart |=> ctxClear && pcLoad && pcTarget == $past(operand) && condFlags == '0)
    else $error("restart incomplete");
  chk_direct_refuse: assert property (
    inExec && (isRestart || isDecBr) && !standaloneMode |=> !pcLoad && !ctxClear && reply_r.status != 8'h64)
    else $error("standalone-only command ran in direct mode");
  chk_decbr_branch: assert property (
    doExec && isDecBr |=> userVar_r[$past(varIdx)] == $past(decVal)
      && pcLoad == ($past(varCur) != 32'h0000_0001) && pcStep == ($past(varCur) == 32'h0000_0001))
    else $error("decrement branch wrong");

endmodule
`default_nettype wire

// ==== tb/vardx_host_model.sv ====
`default_nettype none
module vardx_host_model (
  input wire logic ref_clk,
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output vardx_pkg::vardx_reply_s replyFrame,
  output logic replyDone
);
  timeunit 1ns;
  timeprecision 1ps;
  import vardx_pkg::*;
  logic [71:0] shiftIn = '0;
  int nIn = 0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
    replyFrame = '0;
    replyDone = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // a byte stays up until the edge that takes it
  task automatic send_frame(input vardx_frame_s f, output logic ok);
    logic rdy;
    ok = 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      rxValid <= 1'b1;
      rxData <= f[71-8*i -: 8];
      rdy = 1'b0;
      for (int t = 0; t < 200 && !rdy; t++) begin
        @(negedge ref_clk);
        rdy = rxReady;
        if (!rdy) @(posedge ref_clk);
      end
      ok &= rdy;
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    // released line must not keep the last byte
    rxData <= ~rxData;
  endtask
  ////////////////////////////////////////////////////////////////
  // sink stalls about one cycle in four
  always @(posedge ref_clk) txReady <= ($urandom_range(0, 3) != 0);
  always @(negedge ref_clk) begin
    replyDone <= 1'b0;
    if (txValid && txReady) begin
      shiftIn = {shiftIn[63:0], txData};
      nIn++;
      if (nIn == 9) begin
        replyFrame <= shiftIn;
        replyDone <= 1'b1;
        nIn = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/vardx_exec_test.sv ====
`include "vardx_defines.svh"
`default_nettype none
module vardx_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vardx_pkg::*;
  typedef struct packed {
    logic isReply;
    vardx_reply_s rep;
    logic [2:0] pulse;
    logic [31:0] tgt;
    vardx_flags_s flg;
  } vardx_note_s;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic standaloneMode = 1'b0;
  logic rxValid, rxReady, txValid, txReady, pcLoad, pcStep, ctxClear, replyDone;
  logic [7:0] rxData, txData;
  logic [31:0] pcTarget;
  vardx_flags_s condFlags;
  vardx_reply_s replyFrame;
  logic [31:0] vars [256];
  logic [31:0] lastTgt = '0;
  vardx_flags_s flgExp = '0;
  vardx_note_s notes[$];
  vardx_note_s seen;
  int err_total = 0;
  int check_count = 0;
  initial forever #2 ref_clk = ~ref_clk;
  vardx_exec vardx_exec_inst (.ref_clk(ref_clk), .reset(reset), .standaloneMode(standaloneMode),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txReady(txReady), .pcLoad(pcLoad), .pcStep(pcStep), .pcTarget(pcTarget), .ctxClear(ctxClear),
    .condFlags(condFlags));
  vardx_host_model vardx_host_model_inst (.ref_clk(ref_clk), .rxReady(rxReady), .rxValid(rxValid),
    .rxData(rxData), .txValid(txValid), .txData(txData), .txReady(txReady), .replyFrame(replyFrame),
    .replyDone(replyDone));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] sum8(input logic [63:0] b);
    sum8 = 8'h00;
    for (int i = 0; i < 8; i++) sum8 += b[8*i +: 8];
  endfunction
  ////////////////////////////////////////////////////////////////
  // notes the outcome first, then sends the frame
  task automatic run(input logic [7:0] tgt, opc, typ, bank, input logic [31:0] val, input logic sa, bad);
    vardx_frame_s f;
    vardx_note_s n;
    logic [7:0] st, ix;
    logic [31:0] a, r;
    logic ok;
    f = {tgt, opc, typ, bank, val, 8'h00};
    f.csum = sum8(f[71:8]) ^ {7'h00, bad};
    if (tgt == `VARDX_MODULE_ADDR) begin
      ix = (opc == `VARDX_OPC_DECBR) ? typ : bank;
      a = vars[ix];
      st = `VARDX_STAT_OK;
      n = '0;
      n.pulse = 3'b001;
      if (bad) st = `VARDX_STAT_BAD_CSUM;
      else if (opc == `VARDX_OPC_CALC) begin
        if (typ > 8'h0B || typ == 8'h0A) st = `VARDX_STAT_BAD_TYPE;
        else if ((typ == 8'h03 || typ == 8'h04) && val == '0) st = `VARDX_STAT_BAD_VAL;
        else if (typ == 8'h0B) begin
          flgExp = {a == val, a == val, $signed(a) > $signed(val), $signed(a) < $signed(val)};
        end else begin
          case (typ)
            8'h00: r = a + val;
            8'h01: r = a - val;
            8'h02: r = a * val;
            8'h03: r = $signed(a) / $signed(val);
            8'h04: r = $signed(a) % $signed(val);
            8'h05: r = a & val;
            8'h06: r = a | val;
            8'h07: r = a ^ val;
            8'h08: r = ~a;
            default: r = val;
          endcase
          vars[ix] = r;
          flgExp.zero = (r == '0);
        end
      end else if (!sa) st = `VARDX_STAT_BAD_CMD;
      else if (opc == `VARDX_OPC_RESTART) begin
        n.pulse = 3'b110;
        lastTgt = val;
        flgExp = '0;
      end else if (opc == `VARDX_OPC_DECBR) begin
        vars[ix] = a - 32'h0000_0001;
        if (a != 32'h0000_0001) n.pulse = 3'b010;
        if (a != 32'h0000_0001) lastTgt = val;
      end else st = `VARDX_STAT_BAD_CMD;
      n.isReply = !sa;
      n.rep = {`VARDX_HOST_ADDR, `VARDX_MODULE_ADDR, st, opc, val, 8'h00};
      n.rep.csum = sum8(n.rep[71:8]);
      n.tgt = lastTgt;
      n.flg = flgExp;
      notes.push_back(n);
    end
    standaloneMode <= sa;
    vardx_host_model_inst.send_frame(f, ok);
    // mode is sampled at the execute edge, so the next frame's mode waits for it
    @(posedge ref_clk);
    if (!ok) begin
      err_total++;
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    if (replyDone || pcLoad || pcStep || ctxClear) begin
      if (notes.size() == 0) check("unexpected outcome", 1, 0);
      else begin
        seen = notes.pop_front();
        check("outcome kind", replyDone, seen.isReply);
        if (replyDone) check("reply frame", replyFrame, seen.rep);
        else check("pc pulses", {ctxClear, pcLoad, pcStep}, seen.pulse);
        if (!replyDone) check("pc target", pcTarget, seen.tgt);
        check("flags", condFlags, seen.flg);
      end
    end
  end
  initial begin
    logic [31:0] v;
    logic [7:0] ix;
    void'($urandom(32'h22ea_5f22));
    foreach (vars[i]) vars[i] = '0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'h01, 8'h1B, 32'h0000_1388, 1'b0, 1'b0);
    // every type, then a compare against the value it should have left
    for (int k = 0; k < 39; k++) begin
      ix = 8'($urandom);
      v = (k >= 26) ? 32'h0000_0000 : $urandom;
      run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'(k % 13), ix, v, 1'(k), 1'b0);
      // operand just below, at or just above the variable, so all three orderings occur
      run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'h0B, ix, vars[ix] + 32'(k % 3) - 32'h0000_0001, 1'b0, 1'b0);
    end
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'h00, 8'h05, 32'h0000_0001, 1'b0, 1'b1);
    run(8'h07, `VARDX_OPC_CALC, 8'h09, 8'h05, 32'h0000_0000, 1'b0, 1'b0);
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_RESTART, 8'h00, 8'h00, 32'h0000_000A, 1'b0, 1'b0);
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_DECBR, 8'h2A, 8'h00, 32'h0000_0001, 1'b0, 1'b0);
    run(`VARDX_MODULE_ADDR, 8'h2E, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 1'b0);
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'h09, 8'h2A, 32'h0000_0002, 1'b1, 1'b0);
    // 2 -> 1 jumps, 1 -> 0 falls through, 0 wraps and jumps
    repeat (3) run(`VARDX_MODULE_ADDR, `VARDX_OPC_DECBR, 8'h2A, 8'h00, 32'h0000_0001, 1'b1, 1'b0);
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_RESTART, 8'h55, 8'h66, 32'h0000_000A, 1'b1, 1'b0);
    run(`VARDX_MODULE_ADDR, `VARDX_OPC_CALC, 8'h00, 8'h05, 32'h0000_0001, 1'b1, 1'b1);
    for (int t = 0; t < 200 && notes.size() > 0; t++) @(posedge ref_clk);
    if (notes.size() != 0) err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
